// ---- rtl/pre_pkg.sv ----
// shared constants of the page request event interrupt block
package pre_pkg;
    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_STATUS = 8'hdc;   // pending / overflow flags
    localparam logic [7:0] OFF_CTRL = 8'he0;     // event control register
    localparam logic [7:0] OFF_MDATA = 8'he4;    // message data field
    localparam logic [7:0] OFF_MADDR = 8'he8;    // message address field
    localparam logic [7:0] OFF_IRQ_ST = 8'hf0;   // sticky event status
    localparam logic [7:0] OFF_IRQ_MSK = 8'hf4;  // event interrupt mask
    // status register fields
    localparam int PPR_BIT = 0;                  // pending request flag
    localparam int PRO_BIT = 1;                  // queue overflow flag
    // event control register fields
    localparam int MASK_BIT = 31;                // event mask bit
    localparam int PEND_BIT = 30;                // event pending bit
    localparam int RSV_HI = 29;                  // reserved preserve top
    localparam logic MASK_RESET = 1'b1;
    localparam logic PEND_RESET = 1'b0;
    localparam logic [29:0] RSV_RESET = 30'h0000_0000;
    // message fields
    localparam int MDATA_W = 16;                 // message data width
    localparam int MADDR_LO = 2;                 // address is dword aligned
    localparam logic [15:0] MDATA_RESET = 16'h0000;
    localparam logic [29:0] MADDR_RESET = 30'h0000_0000;
    // sticky interrupt event bits
    localparam int IRQ_W = 3;
    localparam int EV_SENT = 0;                  // message issued
    localparam int EV_DROP = 1;                  // pending serviced, no send
    localparam int EV_OVF = 2;                   // queue overflow seen
    localparam logic [2:0] IRQ_ST_RESET = 3'h0;
    localparam logic [2:0] IRQ_MSK_RESET = 3'h7;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ---- rtl/pre_event_intr.sv ----
// Operation
// - no capability: control reads zero, ignores writes
// - unmasked pending event sends programmed message
// - mask resets set; masked never sends
// - queue entry setting request flag sets pending
// - queue overflow also sets pending
// - only both-flags-clear transition is new condition
// - pending holds while message held back
// - send and clear pending when hold ends
// - servicing request flag clears pending, no send
// - entry sets request flag; write one clears
// - overflow sets overflow flag; write one clears
// - message data is sixteen-bit data field
// - message address is bits 31:2, aligned
`timescale 1ns/100ps
`default_nettype none
module pre_event_intr (
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [pre_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pre_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [pre_pkg::DATA_W-1:0] reg_rdata,
    // queue side events, one-cycle pulses from logic on clk
    input wire logic entry_added,
    input wire logic queue_overflow,
    // capability strap, asynchronous level
    input wire logic page_request_capability,
    // fabric side: ready means a strobe next cycle is accepted
    input wire logic msg_ready,
    output logic msg_valid,
    output logic [31:0] msg_addr,
    output logic [15:0] msg_data,
    // level interrupt
    output logic irq
);
    import pre_pkg::*;

    // the decode compares only the low byte of the address
    if (ADDR_W < 8) begin : g_addr_check
        $error("pre_event_intr: address port narrower than offsets");
    end

    // address match, used for every register
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a[7:0] == off);
    endfunction

    // capability synchroniser; first stage is read only by the second
    logic cap_meta_reg;
    logic cap_reg;

    // state flip-flops
    logic ppr_reg;                 // pending request flag
    logic pro_reg;                 // queue overflow flag
    logic mask_reg;                // event mask bit
    logic pend_reg;                // event pending bit
    logic [15:0] mdata_reg;        // message data field
    logic [29:0] maddr_reg;        // message address bits 31:2
    logic [IRQ_W-1:0] irq_st_reg;  // sticky event status
    logic [IRQ_W-1:0] irq_msk_reg; // event mask, one blocks
    logic msg_valid_reg;
    logic [31:0] msg_addr_reg;
    logic [15:0] msg_data_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;

    // next values
    logic ppr_next;
    logic pro_next;
    logic mask_next;
    logic pend_next;
    logic [IRQ_W-1:0] irq_st_next;
    logic [31:0] rdata_next;

    // register decode
    wire wr_status = reg_write && hit(reg_addr, OFF_STATUS);
    wire wr_ctrl = reg_write && hit(reg_addr, OFF_CTRL) && cap_reg;
    wire wr_mdata = reg_write && hit(reg_addr, OFF_MDATA) && cap_reg;
    wire wr_maddr = reg_write && hit(reg_addr, OFF_MADDR) && cap_reg;
    wire wr_irq_st = reg_write && hit(reg_addr, OFF_IRQ_ST);
    wire wr_irq_msk = reg_write && hit(reg_addr, OFF_IRQ_MSK);

    // events count only when the feature is present
    wire ev_entry = entry_added && cap_reg;
    wire ev_ovf = queue_overflow && cap_reg;

    // a new condition needs both flags clear beforehand
    wire new_cond = (ev_entry || ev_ovf) && !ppr_reg && !pro_reg;

    // software writes one to the request flag while a message waits
    wire svc = wr_status && reg_wdata[PPR_BIT] && pend_reg;

    // fabric not ready is the transient hold; the mask is the other
    wire issue = pend_reg && !mask_reg && msg_ready;

    // a service write that meets an issue is too late to stop it
    wire drop = svc && !issue;

    // flag updates: hardware set wins over the clearing write
    assign ppr_next = ev_entry ||
        (ppr_reg && !(wr_status && reg_wdata[PPR_BIT]));
    assign pro_next = ev_ovf ||
        (pro_reg && !(wr_status && reg_wdata[PRO_BIT]));

    // mask bit, software writable only when the feature exists
    assign mask_next = wr_ctrl ? reg_wdata[MASK_BIT] : mask_reg;

    // pending: set on new condition, else held until issue or service
    assign pend_next = new_cond || (pend_reg && !issue && !svc);

    // sticky events, set wins over write-one-to-clear
    wire [IRQ_W-1:0] irq_set = {ev_ovf, drop, issue};
    wire [IRQ_W-1:0] irq_clr = wr_irq_st ? reg_wdata[IRQ_W-1:0] : '0;
    assign irq_st_next = irq_set | (irq_st_reg & ~irq_clr);

    // read views of each register
    wire [31:0] status_view = {30'h0000_0000, pro_reg, ppr_reg};
    // reserved bits are never altered by writes, so the reset value stands
    wire [31:0] ctrl_view = cap_reg ?
        {mask_reg, pend_reg, RSV_RESET} : ZERO_WORD;
    wire [31:0] mdata_view = cap_reg ? {16'h0000, mdata_reg} : ZERO_WORD;
    wire [31:0] maddr_view = cap_reg ? {maddr_reg, 2'h0} : ZERO_WORD;
    wire [31:0] irq_st_view = {29'h0000_0000, irq_st_reg};
    wire [31:0] irq_msk_view = {29'h0000_0000, irq_msk_reg};

    // read mux; unmapped addresses and idle cycles give zero
    assign rdata_next =
        !reg_read ? ZERO_WORD :
        hit(reg_addr, OFF_STATUS) ? status_view :
        hit(reg_addr, OFF_CTRL) ? ctrl_view :
        hit(reg_addr, OFF_MDATA) ? mdata_view :
        hit(reg_addr, OFF_MADDR) ? maddr_view :
        hit(reg_addr, OFF_IRQ_ST) ? irq_st_view :
        hit(reg_addr, OFF_IRQ_MSK) ? irq_msk_view : ZERO_WORD;

    // capability strap through two flops; absent until seen
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_meta_reg <= 1'b0;
            cap_reg <= 1'b0;
        end else begin
            cap_meta_reg <= page_request_capability;
            cap_reg <= cap_meta_reg;
        end
    end

    // flags and event control state
    always_ff @(posedge clk) begin
        if (reset) begin
            ppr_reg <= 1'b0;
            pro_reg <= 1'b0;
            mask_reg <= MASK_RESET;
            pend_reg <= PEND_RESET;
        end else begin
            ppr_reg <= ppr_next;
            pro_reg <= pro_next;
            mask_reg <= mask_next;
            pend_reg <= pend_next;
        end
    end

    // message data and address fields
    always_ff @(posedge clk) begin
        if (reset) begin
            mdata_reg <= MDATA_RESET;
            maddr_reg <= MADDR_RESET;
        end else begin
            if (wr_mdata) begin
                mdata_reg <= reg_wdata[MDATA_W-1:0];
            end
            if (wr_maddr) begin
                maddr_reg <= reg_wdata[31:MADDR_LO];
            end
        end
    end

    // one-cycle posted write strobe, fields latched with it
    always_ff @(posedge clk) begin
        if (reset) begin
            msg_valid_reg <= 1'b0;
            msg_addr_reg <= ZERO_WORD;
            msg_data_reg <= MDATA_RESET;
        end else begin
            msg_valid_reg <= issue;
            if (issue) begin
                msg_addr_reg <= {maddr_reg, 2'h0};
                msg_data_reg <= mdata_reg;
            end
        end
    end

    // sticky status, mask and level interrupt; irq lags status by one
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_st_reg <= IRQ_ST_RESET;
            irq_msk_reg <= IRQ_MSK_RESET;
            irq_reg <= 1'b0;
        end else begin
            irq_st_reg <= irq_st_next;
            if (wr_irq_msk) begin
                irq_msk_reg <= reg_wdata[IRQ_W-1:0];
            end
            irq_reg <= |(irq_st_reg & ~irq_msk_reg);
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= ZERO_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign msg_valid = msg_valid_reg;
    assign msg_addr = msg_addr_reg;
    assign msg_data = msg_data_reg;
    assign irq = irq_reg;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_ready_to_send;
        pend_reg && !mask_reg && msg_ready;
    endsequence

    property p_send;
        s_ready_to_send |=> msg_valid_reg && !pend_reg;
    endproperty
    a_send: assert property (p_send)
        else $error("unmasked pending event did not send");

    property p_mask_blocks;
        msg_valid_reg |-> $past(!mask_reg);
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("message sent while masked");

    property p_new_sets;
        (ev_entry || ev_ovf) && !ppr_reg && !pro_reg |=> pend_reg;
    endproperty
    a_new_sets: assert property (p_new_sets)
        else $error("new condition did not set pending");

    property p_only_clear_edge;
        $rose(pend_reg) |-> $past(!ppr_reg && !pro_reg);
    endproperty
    a_only_clear_edge: assert property (p_only_clear_edge)
        else $error("pending rose with a flag already set");

    property p_hold;
        pend_reg && mask_reg && !svc |=> pend_reg && !msg_valid_reg;
    endproperty
    a_hold: assert property (p_hold)
        else $error("held message lost pending");

    property p_fall_cause;
        $fell(pend_reg) |-> msg_valid_reg || $past(svc);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("pending cleared without send or service");

    property p_service;
        drop && !new_cond |=> !pend_reg ##1 !msg_valid_reg;
    endproperty
    a_service: assert property (p_service)
        else $error("service did not clear pending quietly");

    property p_flags;
        (ev_entry |=> ppr_reg) and (ev_ovf |=> pro_reg);
    endproperty
    a_flags: assert property (p_flags)
        else $error("status flag not set by its event");

    property p_fields;
        msg_valid_reg |-> msg_data == $past(mdata_reg) &&
            msg_addr == {$past(maddr_reg), 2'h0};
    endproperty
    a_fields: assert property (p_fields)
        else $error("message fields differ from programmed values");

    property p_single;
        msg_valid_reg |=> !msg_valid_reg;
    endproperty
    a_single: assert property (p_single)
        else $error("message strobe longer than one cycle");

    property p_ctrl_read;
        reg_read && hit(reg_addr, OFF_CTRL) |=>
            (!$past(cap_reg) ? reg_rdata == ZERO_WORD :
             reg_rdata[RSV_HI:0] == RSV_RESET);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read value wrong");
endmodule // pre_event_intr
`default_nettype wire

// ---- sim/pre_fabric_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// fabric end: takes posted message writes and stalls when told to
module pre_fabric_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic stall,
    input wire logic msg_valid,
    input wire logic [31:0] msg_addr,
    input wire logic [15:0] msg_data,
    output logic msg_ready,
    output logic [7:0] msg_count,
    output logic [31:0] last_addr,
    output logic [15:0] last_data
);
    // ready trails the stall command by one edge, like a busy fabric
    always_ff @(posedge clk) begin
        if (reset) begin
            msg_ready <= 1'b0;
            msg_count <= 8'h00;
            last_addr <= 32'h0000_0000;
            last_data <= 16'h0000;
        end else begin
            msg_ready <= !stall;
            // every strobe is one whole posted write, counted once
            if (msg_valid) begin
                msg_count <= msg_count + 8'h01;
                last_addr <= msg_addr;
                last_data <= msg_data;
            end
        end
    end
endmodule // pre_fabric_model
`default_nettype wire

// ---- sim/page_request_event_interrupt_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module page_request_event_interrupt_tb_top;
    import pre_pkg::*;
    logic clk, reset, reg_write, reg_read, entry_added, queue_overflow;
    logic page_request_capability, msg_ready, msg_valid, irq, stall;
    logic [7:0] reg_addr, msg_count;
    logic [31:0] reg_wdata, reg_rdata, msg_addr, last_addr, rd_val;
    logic [15:0] msg_data, last_data;
    int errors, compares, cycles;

    pre_event_intr dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .entry_added(entry_added),
        .queue_overflow(queue_overflow),
        .page_request_capability(page_request_capability),
        .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_addr(msg_addr),
        .msg_data(msg_data), .irq(irq));
    pre_fabric_model fabric (.clk(clk), .reset(reset), .stall(stall),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
        .msg_ready(msg_ready), .msg_count(msg_count),
        .last_addr(last_addr), .last_data(last_data));

    // free running clock, 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard: the whole sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rc(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
        rd(a);
        chk(name, rd_val, exp);
    endtask
    // one-cycle queue event: overflow when ovf is set, else an entry
    task automatic pulse(input logic ovf);
        @(posedge clk);
        if (ovf) begin
            queue_overflow <= 1'b1;
        end else begin
            entry_added <= 1'b1;
        end
        @(posedge clk);
        queue_overflow <= 1'b0;
        entry_added <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait for the fabric to have seen n messages
    task automatic wait_msg(input logic [7:0] n);
        for (int i = 0; i < 20 && msg_count !== n; i++) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        reset = 1'b1;
        {reg_write, reg_read, entry_added, queue_overflow} = 4'h0;
        page_request_capability = 1'b1;
        stall = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = ZERO_WORD;
        {errors, compares, cycles} = '0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        idle(3); // capability strap needs two edges to be seen
        rc("ctrl", OFF_CTRL, 32'h8000_0000);
        rc("status", OFF_STATUS, ZERO_WORD);
        rc("irq_mask", OFF_IRQ_MSK, 32'h0000_0007);
        rc("unmapped", 8'h00, ZERO_WORD);
        wr(OFF_CTRL, 32'h3fff_ffff);
        rc("ctrl_rsv", OFF_CTRL, ZERO_WORD);
        wr(OFF_CTRL, 32'h8000_0000);
        wr(OFF_MDATA, 32'hffff_abcd);
        rc("mdata", OFF_MDATA, 32'h0000_abcd);
        wr(OFF_MADDR, 32'h1234_5677);
        rc("maddr", OFF_MADDR, 32'h1234_5674);
        // masked entry: pending must stand, nothing sent
        pulse(1'b0);
        idle(8);
        rc("status_req", OFF_STATUS, 32'h0000_0001);
        rc("ctrl_pend", OFF_CTRL, 32'hc000_0000);
        chk("count_masked", 32'(msg_count), ZERO_WORD);
        wr(OFF_CTRL, ZERO_WORD);
        wait_msg(8'h01);
        chk("count_unmask", 32'(msg_count), 32'h0000_0001);
        chk("msg_addr", last_addr, 32'h1234_5674);
        chk("msg_data", 32'(last_data), 32'h0000_abcd);
        rc("ctrl_done", OFF_CTRL, ZERO_WORD);
        rc("irq_st_sent", OFF_IRQ_ST, 32'h0000_0001);
        chk("irq_blocked", 32'(irq), ZERO_WORD);
        wr(OFF_IRQ_MSK, 32'h0000_0006);
        rc("irq_mask_wr", OFF_IRQ_MSK, 32'h0000_0006);
        chk("irq_on", 32'(irq), 32'h0000_0001);
        wr(OFF_IRQ_ST, 32'h0000_0001);
        idle(2);
        chk("irq_off", 32'(irq), ZERO_WORD);
        // overflow while the request flag still stands: no new condition
        pulse(1'b1);
        idle(8);
        chk("count_nonew", 32'(msg_count), 32'h0000_0001);
        rc("status_both", OFF_STATUS, 32'h0000_0003);
        rc("ctrl_nonew", OFF_CTRL, ZERO_WORD);
        wr(OFF_STATUS, 32'h0000_0003);
        rc("status_clr", OFF_STATUS, ZERO_WORD);
        // only the overflow event bit is left after the sent bit was cleared
        rc("irq_st_ovf", OFF_IRQ_ST, 32'h0000_0004);
        wr(OFF_IRQ_ST, 32'h0000_0007);
        // fabric stalls: overflow held back until ready returns
        stall <= 1'b1;
        pulse(1'b1);
        idle(8);
        rc("ctrl_hold", OFF_CTRL, 32'h4000_0000);
        chk("count_hold", 32'(msg_count), 32'h0000_0001);
        stall <= 1'b0;
        wait_msg(8'h02);
        chk("count_release", 32'(msg_count), 32'h0000_0002);
        idle(10);
        chk("count_once", 32'(msg_count), 32'h0000_0002);
        wr(OFF_STATUS, 32'h0000_0003);
        wr(OFF_IRQ_ST, 32'h0000_0007);
        // request flag serviced while the message is still held
        stall <= 1'b1;
        pulse(1'b0);
        rc("ctrl_held", OFF_CTRL, 32'h4000_0000);
        wr(OFF_STATUS, 32'h0000_0001);
        rc("ctrl_drop", OFF_CTRL, ZERO_WORD);
        stall <= 1'b0;
        idle(10);
        chk("count_drop", 32'(msg_count), 32'h0000_0002);
        rc("irq_st_drop", OFF_IRQ_ST, 32'h0000_0002);
        chk("irq_drop_blk", 32'(irq), ZERO_WORD);
        // feature absent: control is reserved zero
        page_request_capability <= 1'b0;
        idle(4);
        rc("ctrl_nocap", OFF_CTRL, ZERO_WORD);
        wr(OFF_CTRL, 32'h8000_0000);
        rc("ctrl_nocap_wr", OFF_CTRL, ZERO_WORD);
        pulse(1'b0);
        idle(4);
        rc("status_nocap", OFF_STATUS, ZERO_WORD);
        // feature back: the ignored write must not have set the mask
        page_request_capability <= 1'b1;
        idle(4);
        rc("ctrl_cap_back", OFF_CTRL, ZERO_WORD);
        chk("count_nocap", 32'(msg_count), 32'h0000_0002);
        give_verdict();
    end
endmodule // page_request_event_interrupt_tb_top
`default_nettype wire
